// >>> design/ems_io_ctrl.sv
// Interlock, indicator, RF switch, relay and digital I/O control with APB
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - General inputs never affect interlock outputs
// - Interlock closed when loop returns supply
// - First amp shutdown active while interlock open
// - Second amp shutdown active while interlock open
// - Four outputs, each set independently by host
// - Outputs open drain: float inactive, low active
// - Remote indicator follows front indicator exactly
// - Indicator off closed, lit while open
// - Relay rests 1+2/3+4, energized 1+3/2+4
// - Switch 1 when closed, else and reset 0
// - Switch follows interlock only, no host command
// - Host reads four input states any time
// - Host reads open or closed interlock state
module ems_io_ctrl (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        INTLK_LOOP,
  input  wire logic [3:0]  GP_IN,
  input  wire logic [3:0]  GP_OUT_I,
  output logic      [3:0]  GP_OUT_O,
  output logic      [3:0]  GP_OUT_OE,
  output logic             AMP_SHUTDOWN_FIRST,
  output logic             AMP_SHUTDOWN_SECOND,
  output logic             INTERLOCK_INDICATOR,
  output logic             REMOTE_INDICATOR,
  output logic             SOLID_STATE_RF_SWITCH,
  output logic             POWER_TRANSFER_RELAY,
  output logic             IRQ
);
  typedef struct packed {
    logic                      relay;
    logic [ems_pkg::N_OUT-1:0] out_act;
    logic [ems_pkg::N_EV-1:0]  irq_en;
    logic                      closed;
    logic [ems_pkg::N_IN-1:0]  gp_in;
    logic [ems_pkg::N_OUT-1:0] out_pin;
    logic                      pready;
    logic [31:0]               prdata;
    logic                      pslverr;
    logic                      amp1;
    logic                      amp2;
    logic                      ind;
    logic                      rind;
    logic                      ssw;
    logic [ems_pkg::N_OUT-1:0] od_o;
  } st_t;

  st_t q;
  st_t d;

  ems_pkg::apb_req_t req;
  ems_pkg::pin_in_t  pins_raw;
  ems_pkg::pin_in_t  pins;
  logic [ems_pkg::N_SYNC-1:0] pins_sync;

  logic [ems_pkg::N_EV-1:0] ev;
  logic [ems_pkg::N_EV-1:0] clr;
  logic [ems_pkg::N_EV-1:0] stat;
  logic                     irq_w;
  logic                     acc;
  logic                     wr_go;
  logic                     mapped;
  logic [31:0]              rd;

  assign req      = '{sel: PSEL, en: PENABLE, wr: PWRITE, addr: PADDR, wdata: PWDATA};
  assign pins_raw = '{out_pin: GP_OUT_I, gp_in: GP_IN, loop: INTLK_LOOP};
  assign pins     = pins_sync;

  // Pin inputs pass two flops first
  sync_bank #(
    .W(ems_pkg::N_SYNC)
  ) u_sync (
    .clk  (CLK_SYS),
    .rst_n(RST_N),
    .din  (pins_raw),
    .dout (pins_sync)
  );

  event_irq #(
    .N(ems_pkg::N_EV)
  ) u_irq (
    .clk  (CLK_SYS),
    .rst_n(RST_N),
    .ev   (ev),
    .en   (q.irq_en),
    .clr  (clr),
    .stat (stat),
    .irq  (irq_w)
  );

  // Events from state changes
  always_comb begin
    ev                         = '0;
    ev[ems_pkg::EV_OPEN]       = q.closed & ~pins.loop;
    ev[ems_pkg::EV_CLOSE]      = ~q.closed & pins.loop;
    ev[ems_pkg::EV_IN_CHANGE]  = |(q.gp_in ^ pins.gp_in);
  end

  assign acc   = req.sel & req.en;
  assign wr_go = acc & q.pready & req.wr & mapped;

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd     = '0;
    unique case (req.addr)
      ems_pkg::OFF_CTRL: begin
        rd[ems_pkg::CTRL_RELAY_BIT] = q.relay;
      end
      ems_pkg::OFF_OUT: begin
        rd[ems_pkg::N_OUT-1:0] = q.out_act;
        rd[ems_pkg::OUT_PIN_LSB +: ems_pkg::N_OUT] = q.out_pin;
      end
      ems_pkg::OFF_IN: begin
        rd[ems_pkg::N_IN-1:0] = q.gp_in;
      end
      ems_pkg::OFF_INTLK: begin
        rd[ems_pkg::INTLK_CLOSED_BIT] = q.closed;
      end
      ems_pkg::OFF_IRQ_STAT: begin
        rd[ems_pkg::N_EV-1:0] = stat;
      end
      ems_pkg::OFF_IRQ_EN: begin
        rd[ems_pkg::N_EV-1:0] = q.irq_en;
      end
      ems_pkg::OFF_IRQ_CLR: begin
        rd = '0;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    clr = '0;
    if (wr_go && req.addr == ems_pkg::OFF_IRQ_CLR) begin
      clr = req.wdata[ems_pkg::N_EV-1:0];
    end
  end

  always_comb begin
    d = q;
    // One wait state, answer on second access cycle
    d.pready  = acc & ~q.pready;
    d.prdata  = '0;
    d.pslverr = 1'b0;
    if (acc && !q.pready) begin
      d.prdata  = req.wr ? 32'h0000_0000 : rd;
      d.pslverr = ~mapped;
    end
    if (wr_go) begin
      unique case (req.addr)
        ems_pkg::OFF_CTRL: begin
          d.relay = req.wdata[ems_pkg::CTRL_RELAY_BIT];
        end
        ems_pkg::OFF_OUT: begin
          d.out_act = req.wdata[ems_pkg::N_OUT-1:0];
        end
        ems_pkg::OFF_IRQ_EN: begin
          d.irq_en = req.wdata[ems_pkg::N_EV-1:0];
        end
        default: begin
          d.relay = q.relay;
        end
      endcase
    end
    d.closed  = pins.loop;
    d.gp_in   = pins.gp_in;
    d.out_pin = pins.out_pin;
    d.amp1    = ~pins.loop;
    d.amp2    = ~pins.loop;
    d.ind     = ~pins.loop;
    d.rind    = ~pins.loop;
    d.ssw     = pins.loop;
    d.od_o    = '0;
    if (!RST_N) begin
      d         = '0;
      d.relay   = ems_pkg::CTRL_RST;
      d.out_act = ems_pkg::OUT_RST;
      d.irq_en  = ems_pkg::IRQ_EN_RST;
      {d.amp1, d.amp2, d.ind, d.rind} = 4'hF;
      d.ssw     = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    q <= d;
  end

  assign PRDATA                = q.prdata;
  assign PREADY                = q.pready;
  assign PSLVERR               = q.pslverr;
  assign GP_OUT_O              = q.od_o;
  assign GP_OUT_OE             = q.out_act;
  assign AMP_SHUTDOWN_FIRST    = q.amp1;
  assign AMP_SHUTDOWN_SECOND   = q.amp2;
  assign INTERLOCK_INDICATOR   = q.ind;
  assign REMOTE_INDICATOR      = q.rind;
  assign SOLID_STATE_RF_SWITCH = q.ssw;
  assign POWER_TRANSFER_RELAY  = q.relay;
  assign IRQ                   = irq_w;

  // Checks
  logic [1:0] warm_q;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      warm_q <= 2'h0;
    end else if (warm_q != ems_pkg::WARM_MAX) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking

  default disable iff (!RST_N);

  property p_in_sync;
    (warm_q == ems_pkg::WARM_MAX) |-> (q.gp_in == $past(GP_IN, 3));
  endproperty
  a_in_sync: assert property (p_in_sync)
    else $error("general inputs not seen three cycles later");

  property p_loop_state;
    (warm_q == ems_pkg::WARM_MAX) |-> (q.closed == $past(INTLK_LOOP, 3));
  endproperty
  a_loop_state: assert property (p_loop_state)
    else $error("interlock state does not follow loop");

  property p_amp_first;
    (warm_q == ems_pkg::WARM_MAX) |-> (AMP_SHUTDOWN_FIRST == !$past(INTLK_LOOP, 3));
  endproperty
  a_amp_first: assert property (p_amp_first)
    else $error("first amp shutdown wrong");

  property p_amp_second;
    AMP_SHUTDOWN_SECOND == !q.closed;
  endproperty
  a_amp_second: assert property (p_amp_second)
    else $error("second amp shutdown wrong");

  property p_out_write;
    (acc && PREADY && PWRITE && PADDR == ems_pkg::OFF_OUT)
      |=> (GP_OUT_OE == $past(PWDATA[3:0]));
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output channels not set by write");

  property p_open_drain;
    GP_OUT_O == 4'h0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain output driven high");

  property p_remote_ind;
    (REMOTE_INDICATOR == INTERLOCK_INDICATOR) && (INTERLOCK_INDICATOR == !q.closed);
  endproperty
  a_remote_ind: assert property (p_remote_ind)
    else $error("remote indicator differs from front indicator");

  property p_ind_open;
    $fell(q.closed) |-> INTERLOCK_INDICATOR ##1 $stable(INTERLOCK_INDICATOR) || $rose(q.closed);
  endproperty
  a_ind_open: assert property (p_ind_open)
    else $error("indicator not lit on open");

  property p_relay;
    (acc && PREADY && PWRITE && PADDR == ems_pkg::OFF_CTRL)
      |=> (POWER_TRANSFER_RELAY == $past(PWDATA[0]));
  endproperty
  a_relay: assert property (p_relay)
    else $error("relay not set by write");

  property p_ssw_reset;
    !$past(RST_N) |-> !SOLID_STATE_RF_SWITCH;
  endproperty
  a_ssw_reset: assert property (p_ssw_reset)
    else $error("switch not zero after reset");

  property p_ssw_host;
    (acc && PWRITE) |=> (SOLID_STATE_RF_SWITCH == q.closed);
  endproperty
  a_ssw_host: assert property (p_ssw_host)
    else $error("switch moved away from interlock state");

  property p_in_read;
    (acc && !PREADY && !PWRITE && PADDR == ems_pkg::OFF_IN)
      |=> PREADY && (PRDATA[3:0] == $past(q.gp_in));
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input read wrong");

  property p_intlk_read;
    (acc && !PREADY && !PWRITE && PADDR == ems_pkg::OFF_INTLK)
      |=> PREADY && (PRDATA[0] == $past(q.closed));
  endproperty
  a_intlk_read: assert property (p_intlk_read)
    else $error("interlock read wrong");

  property p_in_isolated;
    ($changed(q.gp_in) && $stable(q.closed)) |-> $stable(AMP_SHUTDOWN_FIRST);
  endproperty
  a_in_isolated: assert property (p_in_isolated)
    else $error("general input disturbed interlock output");

  property p_amp_reset;
    !$past(RST_N) |-> AMP_SHUTDOWN_FIRST && AMP_SHUTDOWN_SECOND && INTERLOCK_INDICATOR;
  endproperty
  a_amp_reset: assert property (p_amp_reset)
    else $error("amplifiers not shut down after reset");

  property p_relay_reset;
    !$past(RST_N) |-> !POWER_TRANSFER_RELAY;
  endproperty
  a_relay_reset: assert property (p_relay_reset)
    else $error("relay energized after reset");

  property p_pin_readback;
    (warm_q == ems_pkg::WARM_MAX) |-> (q.out_pin == $past(GP_OUT_I, 3));
  endproperty
  a_pin_readback: assert property (p_pin_readback)
    else $error("output pin readback does not follow pins");

  property p_ev_sticky;
    (|ev) |=> ((stat & $past(ev)) == $past(ev));
  endproperty
  a_ev_sticky: assert property (p_ev_sticky)
    else $error("event not latched in status");

  property p_irq_level;
    IRQ == |(stat & $past(q.irq_en));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level differs from enabled status");

  property p_slverr;
    (acc && !PREADY && !mapped) |=> PREADY && PSLVERR && (PRDATA == 32'h0000_0000);
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not refused");

  c_relay_on: cover property ($rose(POWER_TRANSFER_RELAY));
  c_intlk_close: cover property ($rose(q.closed) ##[1:100] $fell(q.closed));
  c_in_read: cover property (acc && PREADY && !PWRITE && PADDR == ems_pkg::OFF_IN);
  c_irq: cover property ($rose(IRQ));
endmodule

// >>> common/ems_pkg.sv
// Shared constants and carriers of the interlock and I/O control block
package ems_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int N_IN   = 4;
  localparam int N_OUT  = 4;
  localparam int N_EV   = 3;
  localparam int N_SYNC = N_IN + N_OUT + 1;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OUT      = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IN       = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_INTLK    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 8'h18;

  // Field positions
  localparam int CTRL_RELAY_BIT   = 0;
  localparam int INTLK_CLOSED_BIT = 0;
  localparam int OUT_PIN_LSB      = 8;
  localparam int EV_OPEN          = 0;
  localparam int EV_CLOSE         = 1;
  localparam int EV_IN_CHANGE     = 2;

  // Reset values
  localparam logic             CTRL_RST   = 1'h0;
  localparam logic [N_OUT-1:0] OUT_RST    = 4'h0;
  localparam logic [N_EV-1:0]  IRQ_EN_RST = 3'h0;

  // Timing: pin to state latency and reset warm-up in cycles
  localparam int          SYNC_LAT = 3;
  localparam logic [1:0]  WARM_MAX = 2'h3;

  typedef struct packed {
    logic              sel;
    logic              en;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apb_req_t;

  typedef struct packed {
    logic [N_OUT-1:0] out_pin;
    logic [N_IN-1:0]  gp_in;
    logic             loop;
  } pin_in_t;
endpackage

// >>> design/sync_bank.sv
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module sync_bank #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } st_t;

  st_t q;
  st_t d;

  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    if (!rst_n) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign dout = q.s2;
endmodule

// >>> design/event_irq.sv
// Sticky event status with enable mask and one level interrupt
`timescale 1ns/1ps
module event_irq #(
  parameter int N = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] ev,
  input  wire logic [N-1:0] en,
  input  wire logic [N-1:0] clr,
  output logic      [N-1:0] stat,
  output logic              irq
);
  typedef struct packed {
    logic [N-1:0] stat;
    logic         irq;
  } st_t;

  st_t q;
  st_t d;

  always_comb begin
    d      = q;
    // Set wins over a clear in the same cycle
    d.stat = (q.stat & ~clr) | ev;
    d.irq  = |(d.stat & en);
    if (!rst_n) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign stat = q.stat;
  assign irq  = q.irq;
endmodule

// >>> tb/ems_pins_model.sv
// Open-drain output pins with external pull-ups
`timescale 1ns/1ps
module ems_pins_model (
  input  wire logic [3:0] oe,
  input  wire logic [3:0] o,
  output logic      [3:0] pin
);
  // Driven channel pulls low, released channel floats to the pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin[i] = oe[i] ? o[i] : 1'b1;
    end
  end
endmodule

// >>> tb/ems_interlock_io_control_tb_top.sv
// Directed testbench of the interlock and I/O control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module ems_interlock_io_control_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        loop    = 1'b0;
  logic [3:0]  gp_in   = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  out_i;
  logic [3:0]  out_o;
  logic [3:0]  out_oe;
  logic        amp1;
  logic        amp2;
  logic        ind;
  logic        rind;
  logic        rfsw;
  logic        relay;
  logic        irq;
  logic [31:0] rdata;
  logic        rerr;
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #2.5 clk_sys = ~clk_sys;

  ems_io_ctrl ems_io_ctrl_i (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .INTLK_LOOP(loop), .GP_IN(gp_in),
    .GP_OUT_I(out_i), .GP_OUT_O(out_o), .GP_OUT_OE(out_oe),
    .AMP_SHUTDOWN_FIRST(amp1), .AMP_SHUTDOWN_SECOND(amp2),
    .INTERLOCK_INDICATOR(ind), .REMOTE_INDICATOR(rind),
    .SOLID_STATE_RF_SWITCH(rfsw), .POWER_TRANSFER_RELAY(relay), .IRQ(irq)
  );

  ems_pins_model ems_pins_model_i (.oe(out_oe), .o(out_o), .pin(out_i));

  task automatic end_sim;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One APB transfer, held until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rdata)
  endtask

  // Interlock driven outputs for a given loop state
  task automatic chk_loop(input logic closed);
    `CHK("rf_switch", closed, rfsw)
    `CHK("amp_first", ~closed, amp1)
    `CHK("amp_second", ~closed, amp2)
    `CHK("indicator", ~closed, ind)
    `CHK("remote_ind", ind, rind)
  endtask

  initial begin
    #(5 * 5000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (9) @(posedge clk_sys);
    #1;
    `CHK("amp_rst", 1'b1, amp1)
    `CHK("ind_rst", 1'b1, ind)
    `CHK("rf_rst", 1'b0, rfsw)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(5);
    `CHK("relay", 1'b0, relay)
    chk_loop(1'b0);
    rd(ems_pkg::OFF_CTRL, 32'h0);
    rd(ems_pkg::OFF_OUT, 32'h00000F00);
    rd(ems_pkg::OFF_IRQ_EN, 32'h0);
    rd(ems_pkg::OFF_IRQ_STAT, 32'h0);
    rd(ems_pkg::OFF_INTLK, 32'h0);
    // Masked event, then enable and clear
    loop <= 1'b1;
    tick(6);
    chk_loop(1'b1);
    rd(ems_pkg::OFF_INTLK, 32'h1);
    rd(ems_pkg::OFF_IRQ_STAT, 32'h2);
    `CHK("irq_masked", 1'b0, irq)
    wr(ems_pkg::OFF_IRQ_EN, 32'h2);
    tick(2);
    `CHK("irq_on", 1'b1, irq)
    wr(ems_pkg::OFF_IRQ_CLR, 32'h2);
    tick(2);
    `CHK("irq_clr", 1'b0, irq)
    rd(ems_pkg::OFF_IRQ_STAT, 32'h0);
    rd(ems_pkg::OFF_IRQ_CLR, 32'h0);
    // General inputs reach the host only
    gp_in <= 4'hA;
    tick(6);
    rd(ems_pkg::OFF_IN, 32'hA);
    chk_loop(1'b1);
    gp_in <= 4'h5;
    tick(6);
    rd(ems_pkg::OFF_IN, 32'h5);
    rd(ems_pkg::OFF_IRQ_STAT, 32'h4);
    wr(ems_pkg::OFF_IRQ_EN, 32'h1);
    loop <= 1'b0;
    tick(6);
    chk_loop(1'b0);
    `CHK("irq_open", 1'b1, irq)
    rd(ems_pkg::OFF_INTLK, 32'h0);
    rd(ems_pkg::OFF_IRQ_STAT, 32'h5);
    wr(ems_pkg::OFF_IRQ_CLR, 32'h7);
    // Each output channel alone
    for (int i = 0; i < 4; i++) begin
      wr(ems_pkg::OFF_OUT, 32'h1 << i);
      tick(1);
      `CHK("out_oe", 4'h1 << i, out_oe)
      `CHK("out_o", 4'h0, out_o)
      tick(4);
      rd(ems_pkg::OFF_OUT, ((~(32'h1 << i) & 32'hF) << 8) | (32'h1 << i));
    end
    // Relay under host control, switch left alone
    wr(ems_pkg::OFF_CTRL, 32'hFFFFFFFF);
    tick(1);
    `CHK("relay_on", 1'b1, relay)
    `CHK("rf_host", 1'b0, rfsw)
    apb(1'b0, ems_pkg::OFF_CTRL, 32'h0);
    `CHK("ctrl", 1'b1, rdata[0])
    wr(ems_pkg::OFF_CTRL, 32'h0);
    tick(1);
    `CHK("relay_off", 1'b0, relay)
    // Unmapped and read-only places
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, rerr)
    `CHK("unmapped", 32'h0, rdata)
    wr(ems_pkg::OFF_IN, 32'hF);
    `CHK("ro_err", 1'b0, rerr)
    rd(ems_pkg::OFF_IN, 32'h5);
    end_sim();
  end
endmodule
